// file: shared/alsc_pkg.sv
/*
 * Constants, register map and mode types for the airfield lamp
 * state controller. Assumes a 40 MHz hclk and at most two lamps.
 */
// Summary of operation
// - On circuit energize, drive each lamp to its configured power-up state.
// - Switch each lamp on, off or flashing as the received command asks.
// - One lamp output for single variant, two independent outputs for dual.
// - Master starts every exchange; the unit only answers, never volunteers.
// - After a programmed silence from the master, apply the safe states.
// - Safe state choices: on, off, flashing, or leave the lamp unchanged.
// - Keep lamp state through current loss; restore it if memory enabled.
// - An applicable restored state wins over the power-up state.
// - Optional outage limit of 1 to 20 s forces power-up state instead.
// - With soft switching on, delay physical switching by 10 ms steps.
// - The acknowledge and its timing ignore any soft switching delay.
// - Report filament condition and lamp state: on, off, flash, defective.
// - When enabled, actively report failed lamps as defective.
package alsc_pkg;

	localparam int ALSC_LAMPS = 2;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_TIMEOUT  = 8'h04;
	localparam logic [7:0] ADDR_LIMIT    = 8'h08;
	localparam logic [7:0] ADDR_SOFT     = 8'h0c;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ST   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	localparam int CTRL_PWRUP_LSB = 0;
	localparam int CTRL_SAFE_LSB  = 4;
	localparam int CTRL_MEM_BIT   = 8;
	localparam int CTRL_LIMIT_BIT = 9;
	localparam int CTRL_SOFT_BIT  = 10;
	localparam int CTRL_AFAIL_BIT = 11;

	localparam logic [11:0] CTRL_RST    = 12'h000;
	localparam logic [15:0] TIMEOUT_RST = 16'h03e8;
	localparam logic [4:0]  LIMIT_RST   = 5'h14;
	localparam logic [7:0]  SOFT_RST    = 8'h00;

	localparam int ST_TGT_LSB  = 0;
	localparam int ST_FAIL_LSB = 4;
	localparam int ST_LOST_BIT = 6;
	localparam int ST_MEM_BIT  = 7;
	localparam int ST_EN_BIT   = 8;
	localparam int ST_DRV_LSB  = 9;

	localparam int IRQ_W    = 4;
	localparam int IRQ_COMM = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_LOSS = 2;
	localparam int IRQ_CMD  = 3;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 25;
	localparam int MS_NS          = 1_000_000;
	localparam int ALSC_MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int STEP_MS        = 10;
	localparam int FLASH_HALF_MS  = 500;
	localparam int RETAIN_MS      = 20000;
	localparam int MS_PER_S       = 1000;

	typedef enum logic [1:0] {LM_OFF, LM_ON, LM_FLASH, LM_KEEP} alsc_mode_type;
	typedef enum logic [1:0] {LS_OFF, LS_ON, LS_FLASH, LS_DEFECT} alsc_stat_type;

endpackage

// file: logic/alsc_tick.sv
/*
 * Free running prescaler giving a one-cycle pulse every DIV clocks.
 * Assumes DIV of at least two.
 */
`timescale 1ns/1ps
module alsc_tick
	import alsc_pkg::*;
#(
	parameter int DIV = ALSC_MS_CYCLES
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Pulse out
	output wire logic tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} alsc_tick_type;

	alsc_tick_type s_reg;
	alsc_tick_type s_next;

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.cnt == LAST) begin
			s_next.cnt = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
endmodule

// file: logic/alsc_lamp.sv
/*
 * One lamp channel: commanded mode, optional soft switching delay
 * and the physical drive. Assumes a 1 ms tick and a shared flash phase.
 */
`timescale 1ns/1ps
module alsc_lamp
	import alsc_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Timing
	input  wire logic       ms_tick,
	input  wire logic       flash_phase,
	input  wire logic       energized,
	// Mode request
	input  wire logic       set_valid,
	input  wire logic [1:0] set_mode,
	input  wire logic       set_soft,
	input  wire logic [7:0] soft_steps,
	// Channel out
	output wire logic [1:0] target,
	output wire logic       drive
);
	typedef struct packed {
		logic [1:0]  target;
		logic [1:0]  applied;
		logic [11:0] dly;
		logic        pend;
		logic        drive;
	} alsc_lamp_type;

	alsc_lamp_type s_reg;
	alsc_lamp_type s_next;

	always_comb begin
		s_next = s_reg;
		if (set_valid && set_mode != LM_KEEP) begin
			s_next.target = set_mode;
			if (set_soft && soft_steps != 8'h00) begin
				s_next.dly = 12'(soft_steps) * 12'(STEP_MS);
				s_next.pend = 1'b1;
			end else begin
				s_next.applied = set_mode;
				s_next.pend = 1'b0;
			end
		end else if (s_reg.pend && ms_tick) begin
			s_next.dly = s_reg.dly - 12'h001;
			if (s_reg.dly == 12'h001) begin
				s_next.applied = s_reg.target;
				s_next.pend = 1'b0;
			end
		end
		// No current, no light, whatever the mode
		s_next.drive = energized && (s_next.applied == LM_ON ||
			(s_next.applied == LM_FLASH && flash_phase));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign target = s_reg.target;
	assign drive  = s_reg.drive;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	drive_on_a: assert property ((set_valid && !set_soft &&
		set_mode == LM_ON && energized) |=> drive)
		else $error("lamp not driven after on command");
	soft_hold_a: assert property ((set_valid && set_soft &&
		soft_steps != 8'h00 && set_mode != LM_KEEP) |=>
		s_reg.applied == $past(s_reg.applied) && s_reg.pend)
		else $error("soft switch applied without delay");
	keep_mode_a: assert property ((set_valid &&
		set_mode == LM_KEEP) |=> target == $past(target))
		else $error("keep request changed lamp mode");
endmodule

// file: logic/alsc_top.sv
/*
 * Airfield lamp state controller: AHB-Lite register slave, link
 * command handling, power-up, safe state, command memory, status
 * reply and interrupt. Assumes a decoded link delivering one valid
 * frame as a pulse, and a synchronous circuit-energized level.
 */
`timescale 1ns/1ps
module alsc_top
	import alsc_pkg::*;
#(
	parameter int LAMPS     = ALSC_LAMPS,
	parameter int MS_CYCLES = ALSC_MS_CYCLES
) (
	// Clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output wire logic [31:0]          hrdata,
	output wire logic                 hreadyout,
	output wire logic                 hresp,
	// Link from master
	input  wire logic                 link_frame_valid,
	input  wire logic [2*LAMPS-1:0]   link_frame_cmd,
	output wire logic                 link_resp_valid,
	output wire logic [3*LAMPS-1:0]   link_resp_status,
	// Series circuit and lamps
	input  wire logic                 circuit_energized,
	input  wire logic [LAMPS-1:0]     lamp_fail,
	output wire logic [LAMPS-1:0]     lamp_drive,
	// Interrupt
	output wire logic                 irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic               ap_valid;
		logic               ap_write;
		logic [7:0]         ap_addr;
		logic [31:0]        hrdata;
		logic               hreadyout;
		logic [11:0]        ctrl;
		logic [15:0]        timeout;
		logic [4:0]         limit_s;
		logic [7:0]         soft_steps;
		logic [IRQ_W-1:0]   irq_st;
		logic [IRQ_W-1:0]   irq_mask;
		logic               irq;
		logic               en_d;
		logic [LAMPS-1:0]   fail_d;
		logic [15:0]        comm_cnt;
		logic               comm_lost;
		logic [15:0]        outage_ms;
		logic               mem_valid;
		logic [2*LAMPS-1:0] mem_mode;
		logic [9:0]         flash_cnt;
		logic               flash_phase;
		logic [LAMPS-1:0]   set_valid;
		logic [2*LAMPS-1:0] set_mode;
		logic               set_soft;
		logic               resp_valid;
		logic [3*LAMPS-1:0] resp;
	} alsc_top_type;

	alsc_top_type s_reg;
	alsc_top_type s_next;

	logic               ms_tick;
	logic [2*LAMPS-1:0] lamp_target;
	logic [2*LAMPS-1:0] pwrup_all;
	logic [2*LAMPS-1:0] safe_all;
	logic [15:0]        limit_ms;
	logic               rise;
	logic               fall;
	logic               take;
	logic               restore_ok;

	assign pwrup_all = s_reg.ctrl[CTRL_PWRUP_LSB +: 2*LAMPS];
	assign safe_all  = s_reg.ctrl[CTRL_SAFE_LSB +: 2*LAMPS];
	assign limit_ms  = 16'(s_reg.limit_s) * 16'(MS_PER_S);
	assign rise      = circuit_energized && !s_reg.en_d;
	assign fall      = !circuit_energized && s_reg.en_d;
	// Frames count only once the circuit has settled for a cycle
	assign take      = link_frame_valid && circuit_energized && s_reg.en_d;
	assign restore_ok = s_reg.ctrl[CTRL_MEM_BIT] && s_reg.mem_valid &&
		(!s_reg.ctrl[CTRL_LIMIT_BIT] || s_reg.outage_ms <= limit_ms);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [31:0]      rd;
		logic [IRQ_W-1:0] irq_set;
		logic [IRQ_W-1:0] irq_clr;
		logic [1:0]       md;
		rd = '0;
		irq_set = '0;
		irq_clr = '0;
		md = '0;
		s_next = s_reg;
		s_next.en_d = circuit_energized;
		s_next.fail_d = lamp_fail;
		s_next.set_valid = '0;
		s_next.set_soft = 1'b0;
		s_next.resp_valid = 1'b0;

		// Data phase of a write
		if (s_reg.ap_valid && s_reg.ap_write) begin
			case (s_reg.ap_addr)
				ADDR_CTRL: begin
					s_next.ctrl = hwdata[11:0];
				end
				ADDR_TIMEOUT: begin
					s_next.timeout = hwdata[15:0];
				end
				ADDR_LIMIT: begin
					s_next.limit_s = hwdata[4:0];
				end
				ADDR_SOFT: begin
					s_next.soft_steps = hwdata[7:0];
				end
				ADDR_IRQ_ST: begin
					irq_clr = hwdata[IRQ_W-1:0];
				end
				ADDR_IRQ_MASK: begin
					s_next.irq_mask = hwdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Flash phase
		if (ms_tick) begin
			if (s_reg.flash_cnt == 10'(FLASH_HALF_MS - 1)) begin
				s_next.flash_cnt = '0;
				s_next.flash_phase = !s_reg.flash_phase;
			end else begin
				s_next.flash_cnt = s_reg.flash_cnt + 10'h001;
			end
		end

		// Retention across current loss
		if (fall) begin
			s_next.mem_mode = lamp_target;
			s_next.mem_valid = 1'b1;
			s_next.outage_ms = '0;
			irq_set[IRQ_LOSS] = 1'b1;
		end else if (!circuit_energized && ms_tick) begin
			if (s_reg.outage_ms != 16'hffff) begin
				s_next.outage_ms = s_reg.outage_ms + 16'h0001;
			end
			// Memory only lasts a limited time without current
			if (s_reg.outage_ms >= 16'(RETAIN_MS)) begin
				s_next.mem_valid = 1'b0;
			end
		end

		if (rise) begin
			s_next.set_valid = '1;
			s_next.set_mode = restore_ok ? s_reg.mem_mode :
				pwrup_all;
			s_next.comm_cnt = '0;
			s_next.comm_lost = 1'b0;
		end else if (take) begin
			s_next.comm_cnt = '0;
			s_next.comm_lost = 1'b0;
			s_next.set_valid = '1;
			s_next.set_mode = link_frame_cmd;
			s_next.set_soft = s_reg.ctrl[CTRL_SOFT_BIT];
			// Answer now, not after any soft delay
			s_next.resp_valid = 1'b1;
			irq_set[IRQ_CMD] = 1'b1;
			for (int i = 0; i < LAMPS; i++) begin
				md = link_frame_cmd[2*i +: 2];
				if (md == LM_KEEP) begin
					md = lamp_target[2*i +: 2];
				end
				if (s_reg.ctrl[CTRL_AFAIL_BIT] && lamp_fail[i]) begin
					md = LS_DEFECT;
				end
				s_next.resp[3*i +: 3] = {!lamp_fail[i], md};
			end
		end else if (circuit_energized && s_reg.en_d && ms_tick &&
			!s_reg.comm_lost && s_reg.timeout != 16'h0000) begin
			if (s_reg.comm_cnt >= s_reg.timeout - 16'h0001) begin
				s_next.comm_lost = 1'b1;
				s_next.set_valid = '1;
				s_next.set_mode = safe_all;
				irq_set[IRQ_COMM] = 1'b1;
			end else begin
				s_next.comm_cnt = s_reg.comm_cnt + 16'h0001;
			end
		end

		// A new event beats a clear in the same cycle
		irq_set[IRQ_FAIL] = |(lamp_fail & ~s_reg.fail_d);
		s_next.irq_st = (s_reg.irq_st & ~irq_clr) | irq_set;
		s_next.irq = |(s_next.irq_st & s_next.irq_mask);

		// Address phase; reads see any write finishing now
		s_next.ap_valid = hsel && hready && htrans[1];
		s_next.ap_write = hwrite;
		s_next.ap_addr = haddr[7:0];
		case (haddr[7:0])
			ADDR_CTRL: begin
				rd[11:0] = s_next.ctrl;
			end
			ADDR_TIMEOUT: begin
				rd[15:0] = s_next.timeout;
			end
			ADDR_LIMIT: begin
				rd[4:0] = s_next.limit_s;
			end
			ADDR_SOFT: begin
				rd[7:0] = s_next.soft_steps;
			end
			ADDR_STATUS: begin
				rd[ST_TGT_LSB +: 2*LAMPS] = lamp_target;
				rd[ST_FAIL_LSB +: LAMPS] = lamp_fail;
				rd[ST_LOST_BIT] = s_reg.comm_lost;
				rd[ST_MEM_BIT] = s_reg.mem_valid;
				rd[ST_EN_BIT] = s_reg.en_d;
				rd[ST_DRV_LSB +: LAMPS] = lamp_drive;
			end
			ADDR_IRQ_ST: begin
				rd[IRQ_W-1:0] = s_next.irq_st;
			end
			ADDR_IRQ_MASK: begin
				rd[IRQ_W-1:0] = s_next.irq_mask;
			end
			default: begin
			end
		endcase
		s_next.hrdata = (s_next.ap_valid && !hwrite) ? rd : '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			s_reg.hreadyout <= 1'b1;
			s_reg.ctrl <= CTRL_RST;
			s_reg.timeout <= TIMEOUT_RST;
			s_reg.limit_s <= LIMIT_RST;
			s_reg.soft_steps <= SOFT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Children
	// ****************************************
	alsc_tick #(
		.DIV (MS_CYCLES)
	) alsc_tick_inst (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (ms_tick)
	);

	// One independent channel per lamp
	for (genvar g = 0; g < LAMPS; g++) begin : g_lamp
		alsc_lamp alsc_lamp_inst (
			.hclk        (hclk),
			.hresetn     (hresetn),
			.ms_tick     (ms_tick),
			.flash_phase (s_reg.flash_phase),
			.energized   (circuit_energized),
			.set_valid   (s_reg.set_valid[g]),
			.set_mode    (s_reg.set_mode[2*g +: 2]),
			.set_soft    (s_reg.set_soft),
			.soft_steps  (s_reg.soft_steps),
			.target      (lamp_target[2*g +: 2]),
			.drive       (lamp_drive[g])
		);
	end

	assign hrdata           = s_reg.hrdata;
	assign hreadyout        = s_reg.hreadyout;
	assign hresp            = 1'b0;
	assign link_resp_valid  = s_reg.resp_valid;
	assign link_resp_status = s_reg.resp;
	assign irq              = s_reg.irq;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	ack_timing_a: assert property (take |=> link_resp_valid)
		else $error("frame not acknowledged next cycle");
	no_unsolicited_a: assert property (link_resp_valid |->
		$past(take))
		else $error("reply sent without a frame");
	powerup_state_a: assert property ((rise && !restore_ok)
		##1 !take |=> lamp_target == $past(pwrup_all, 2))
		else $error("power-up state not applied");
	restore_first_a: assert property ((rise && restore_ok)
		##1 !take |=> lamp_target == $past(s_reg.mem_mode, 2))
		else $error("remembered state not restored");
	outage_limit_a: assert property ((rise &&
		s_reg.ctrl[CTRL_LIMIT_BIT] && s_reg.outage_ms > limit_ms)
		|-> !restore_ok)
		else $error("outage limit ignored");
	retain_state_a: assert property (fall |=> s_reg.mem_valid &&
		s_reg.mem_mode == $past(lamp_target))
		else $error("lamp state not retained on loss");
	safe_state_a: assert property ($rose(s_reg.comm_lost) |->
		s_reg.set_valid == '1 && s_reg.set_mode == $past(safe_all))
		else $error("safe state not issued on timeout");
	timer_restart_a: assert property (take |=>
		s_reg.comm_cnt == 16'h0000 && !s_reg.comm_lost)
		else $error("silence timer not restarted");
	fail_report_a: assert property ((take && lamp_fail[0] &&
		s_reg.ctrl[CTRL_AFAIL_BIT]) |=> link_resp_status[1:0] == LS_DEFECT)
		else $error("failed lamp not reported defective");
	filament_a: assert property (take |=>
		link_resp_status[2] == !$past(lamp_fail[0]))
		else $error("filament bit wrong in reply");
	irq_level_a: assert property (irq == |(s_reg.irq_st & s_reg.irq_mask))
		else $error("interrupt output disagrees with status");

	cmd_seen_c: cover property (take ##1 link_resp_valid);
	timeout_c: cover property ($rose(s_reg.comm_lost));
	restore_c: cover property (rise && restore_ok);
endmodule

// file: bench/alsc_master_model.sv
/*
 * Master controller model for the lamp unit's link: it starts every
 * exchange with a one-cycle frame pulse and collects the reply.
 * Assumes one calling process and a reply within eight cycles.
 */
`timescale 1ns/1ps
module alsc_master_model
	import alsc_pkg::*;
#(
	parameter int LAMPS = ALSC_LAMPS
) (
	// Clock
	input  wire logic               hclk,
	// Link
	output logic                    link_frame_valid,
	output logic [2*LAMPS-1:0]      link_frame_cmd,
	input  wire logic               link_resp_valid,
	input  wire logic [3*LAMPS-1:0] link_resp_status
);
	int frames = 0;
	int replies = 0;

	initial begin
		link_frame_valid = 1'b0;
		link_frame_cmd = '0;
	end

	// Unsolicited replies would show up as a surplus here
	always @(negedge hclk) begin
		if (link_resp_valid === 1'b1)
			replies++;
	end

	// Command lines carry garbage once the pulse is over
	task automatic exchange(input logic [2*LAMPS-1:0] cmd,
		output logic [3*LAMPS-1:0] st, output int lat);
		@(posedge hclk);
		link_frame_valid <= 1'b1;
		link_frame_cmd <= cmd;
		frames++;
		@(posedge hclk);
		link_frame_valid <= 1'b0;
		link_frame_cmd <= ~cmd;
		st = '0;
		for (lat = 1; lat < 9; lat++) begin
			@(negedge hclk);
			if (link_resp_valid === 1'b1) begin
				st = link_resp_status;
				break;
			end
		end
	endtask
endmodule

// file: bench/alsc_top_test.sv
/*
 * Self-checking bench for the lamp state controller: AHB-Lite master
 * tasks, link master model, random and corner-case commands.
 * Assumes the 1 ms tick is shortened to four clocks.
 */
`timescale 1ns/1ps
module alsc_top_test;
	import alsc_pkg::*;

	localparam int MSC = 4;
	localparam logic [7:0] RA [7] = '{ADDR_CTRL, ADDR_TIMEOUT, ADDR_LIMIT,
		ADDR_SOFT, ADDR_IRQ_ST, ADDR_IRQ_MASK, 8'h1c};
	localparam logic [31:0] RV [7] = '{32'(CTRL_RST), 32'(TIMEOUT_RST),
		32'(LIMIT_RST), 32'(SOFT_RST), '0, '0, '0};
	localparam logic [31:0] RW [7] = '{32'h0000_0fff, 32'h0000_ffff,
		32'h0000_001f, 32'h0000_00ff, '0, 32'h0000_000f, '0};

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic        circuit_energized = 1'b0;
	logic [1:0]  lamp_fail = '0;
	logic [31:0] rd_s;
	logic        rdy_s;
	wire logic [31:0] hrdata;
	wire logic        hreadyout;
	wire logic        hresp;
	wire logic        link_frame_valid;
	wire logic [3:0]  link_frame_cmd;
	wire logic        link_resp_valid;
	wire logic [5:0]  link_resp_status;
	wire logic [1:0]  lamp_drive;
	wire logic        irq;
	int err_count = 0;
	int checks = 0;

	always #12.5 hclk = ~hclk;

	// Value standing at the coming rising edge
	always @(negedge hclk) begin
		rd_s <= hrdata;
		rdy_s <= hreadyout;
	end

	alsc_top #(
		.LAMPS     (2),
		.MS_CYCLES (MSC)
	) alsc_top_inst (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.hsel              (1'b1),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (3'b010),
		.hwdata            (hwdata),
		.hready            (hreadyout),
		.hrdata            (hrdata),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.link_frame_valid  (link_frame_valid),
		.link_frame_cmd    (link_frame_cmd),
		.link_resp_valid   (link_resp_valid),
		.link_resp_status  (link_resp_status),
		.circuit_energized (circuit_energized),
		.lamp_fail         (lamp_fail),
		.lamp_drive        (lamp_drive),
		.irq               (irq)
	);

	alsc_master_model #(
		.LAMPS (2)
	) alsc_master_model_inst (
		.hclk             (hclk),
		.link_frame_valid (link_frame_valid),
		.link_frame_cmd   (link_frame_cmd),
		.link_resp_valid  (link_resp_valid),
		.link_resp_status (link_resp_status)
	);

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic results;
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h",
				$time, msg, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge hclk);
		htrans <= 2'b10;
		haddr[7:0] <= a;
		hwrite <= wr;
		do begin
			@(posedge hclk);
			n++;
		end while (rdy_s !== 1'b1 && n < 50);
		// An address phase that never ended counts as a timeout
		if (rdy_s !== 1'b1) begin
			n = 100;
		end
		htrans <= 2'b00;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			n++;
		end while (rdy_s !== 1'b1 && n < 100);
		rd = rd_s;
		if (n >= 100) begin
			cmp(32'(n), 32'h0000_0000, "bus wait ran out");
			results();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] junk;
		bus(1'b1, a, d, junk);
	endtask

	task automatic wait_lamp(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (lamp_drive[i] !== v && n < lim) begin
			@(negedge hclk);
			n++;
		end
		cmp(32'(lamp_drive[i]), 32'(v), "lamp drive");
	endtask

	function automatic logic [5:0] exp_st(input logic [3:0] m,
		input logic [1:0] f, input logic af);
		logic [5:0] s;
		for (int i = 0; i < 2; i++) begin
			s[3*i+2] = ~f[i];
			s[3*i +: 2] = (af && f[i]) ? 2'b11 : m[2*i +: 2];
		end
		return s;
	endfunction

	function automatic logic [3:0] next_m(input logic [3:0] m,
		input logic [3:0] c);
		for (int i = 0; i < 2; i++)
			if (c[2*i +: 2] != 2'b11)
				m[2*i +: 2] = c[2*i +: 2];
		return m;
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic [5:0]  st;
		logic [3:0]  m;
		logic [3:0]  c;
		logic [1:0]  f;
		int          lat;
		int          seed;
		int          cyc [3];
		seed = 32'h7e9c_930f;
		cyc = '{40, 3200, 4400};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, RA[i], '0, r);
			cmp(r, RV[i], "reset value");
			cmp(32'(hresp), 32'h0000_0000, "bus response");
			wr(RA[i], 32'hffff_ffff);
			bus(1'b0, RA[i], '0, r);
			cmp(r, RW[i], "access width");
			wr(RA[i], RV[i]);
		end
		wr(ADDR_CTRL, 32'h0000_0009);
		@(posedge hclk);
		circuit_energized <= 1'b1;
		repeat (6) @(negedge hclk);
		bus(1'b0, ADDR_STATUS, '0, r);
		cmp(32'(r[3:0]), 32'h0000_0009, "power-up modes");
		cmp(32'(lamp_drive[0]), 32'h0000_0001, "power-up on");
		m = 4'h9;
		for (int k = 0; k < 24; k++) begin
			c = (k < 4) ? {2'(k), 2'(k)} : 4'($random(seed));
			f = 2'($random(seed));
			@(posedge hclk);
			lamp_fail <= f;
			m = next_m(m, c);
			alsc_master_model_inst.exchange(c, st, lat);
			cmp(32'(lat), 32'h0000_0001, "reply delay");
			cmp(32'(st), 32'(exp_st(m, f, 1'b0)), "reply");
			repeat (2) @(negedge hclk);
			for (int i = 0; i < 2; i++)
				if (m[2*i +: 2] != 2'b10)
					cmp(32'(lamp_drive[i]), 32'(m[2*i]), "drive");
		end
		bus(1'b0, ADDR_STATUS, '0, r);
		cmp(32'(r[5:0]), 32'({f, m}), "status modes");
		@(posedge hclk);
		lamp_fail <= 2'b00;
		wr(ADDR_IRQ_ST, 32'h0000_000f);
		wr(ADDR_IRQ_MASK, 32'h0000_0002);
		wr(ADDR_CTRL, 32'h0000_0809);
		@(negedge hclk);
		cmp(32'(irq), 32'h0000_0000, "irq idle");
		@(posedge hclk);
		lamp_fail <= 2'b01;
		repeat (3) @(negedge hclk);
		cmp(32'(irq), 32'h0000_0001, "irq on fail");
		alsc_master_model_inst.exchange(4'b0101, st, lat);
		cmp(32'(st), 32'(exp_st(4'b0101, 2'b01, 1'b1)), "defect");
		wr(ADDR_IRQ_ST, 32'h0000_0002);
		bus(1'b0, ADDR_IRQ_ST, '0, r);
		cmp(32'(r[1]), 32'h0000_0000, "fail flag cleared");
		cmp(32'(irq), 32'h0000_0000, "irq masked");
		@(posedge hclk);
		lamp_fail <= 2'b00;
		// Two 10 ms steps: drive must lag well behind the reply
		wr(ADDR_SOFT, 32'h0000_0002);
		wr(ADDR_CTRL, 32'h0000_0400);
		alsc_master_model_inst.exchange(4'b0000, st, lat);
		cmp(32'(lat), 32'h0000_0001, "soft reply delay");
		repeat (60) @(negedge hclk);
		cmp(32'(lamp_drive), 32'h0000_0003, "soft hold");
		wait_lamp(0, 1'b0, 60);
		wr(ADDR_SOFT, 32'h0000_0000);
		wr(ADDR_TIMEOUT, 32'h0000_0005);
		for (int s = 0; s < 4; s++) begin
			c = {2'b11, (s == 1) ? 2'b00 : 2'b01};
			wr(ADDR_CTRL, 32'({2'b11, 2'(s)}) << 4);
			for (int j = 0; j < 3; j++) begin
				alsc_master_model_inst.exchange(c, st, lat);
				repeat (12) @(negedge hclk);
				cmp(32'(lamp_drive[0]), 32'(c[0]), "no early safe");
			end
			repeat (30) @(negedge hclk);
			bus(1'b0, ADDR_STATUS, '0, r);
			cmp(32'(r[1:0]), (s == 3) ? 32'(c[1:0]) : 32'(s), "safe");
			cmp(32'(r[6]), 32'h0000_0001, "comm lost");
		end
		wr(ADDR_TIMEOUT, 32'h0000_0000);
		wr(ADDR_LIMIT, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL, (i > 0) ? 32'h0000_0300 : 32'h0000_0100);
			alsc_master_model_inst.exchange(4'b1001, st, lat);
			@(posedge hclk);
			circuit_energized <= 1'b0;
			if (i == 0) begin
				alsc_master_model_inst.exchange(4'b0101, st, lat);
				cmp(32'(lat), 32'h0000_0009, "refused frame");
			end
			repeat (cyc[i]) @(posedge hclk);
			circuit_energized <= 1'b1;
			repeat (6) @(negedge hclk);
			bus(1'b0, ADDR_STATUS, '0, r);
			cmp(32'(r[3:0]), (i < 2) ? 32'h0000_0009 : '0, "restore");
			// Restored flashing lamp must toggle within one half period
			if (i == 0) begin
				@(negedge hclk);
				wait_lamp(1, !lamp_drive[1], FLASH_HALF_MS * MSC + 8);
			end
		end
		cmp(32'(alsc_master_model_inst.replies),
			32'(alsc_master_model_inst.frames - 1), "reply count");
		results();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge hclk);
		cmp(32'h0000_0001, 32'h0000_0000, "run did not finish");
		results();
	end
endmodule
